/* logic/svwd_consts.svh */
`ifndef SVWD_CONSTS_SVH
`define SVWD_CONSTS_SVH
// control register bit positions
`define SVWD_BIT_DLY_HI 7
`define SVWD_BIT_WD_HI 6
`define SVWD_BIT_WD_LO 5
`define SVWD_BIT_PROT 4
`define SVWD_BIT_REG_WRITE_LATCH 2
`define SVWD_BIT_WEL 1
`define SVWD_BIT_DLY_LO 0
// factory nonvolatile settings: delay 01, watchdog off, no protect
`define SVWD_NV_RESET 5'h0d
// bus codes
`define SVWD_CREG_ADDR 9'h1ff
`define SVWD_CREG_PRE 4'hb
`define SVWD_PROG_DEV 8'ha0
`define SVWD_PROG_V1_SET 8'h01
`define SVWD_PROG_V2_SET 8'h09
`define SVWD_PROG_V1_CLR 8'h03
`define SVWD_PROG_V2_CLR 8'h0b
`define SVWD_DATA_WEL_SET 8'h02
`define SVWD_DATA_WEL_CLR 8'h00
`define SVWD_PROT_BASE 9'h100
// times in milliseconds, clock in kHz
`define SVWD_CLK_KHZ 50000
`define SVWD_WD0_MS 1400
`define SVWD_WD1_MS 200
`define SVWD_WD2_MS 25
`define SVWD_PU0_MS 50
`define SVWD_PU1_MS 200
`define SVWD_PU2_MS 400
`define SVWD_PU3_MS 800
`define SVWD_NVW_MS 10
`endif

/* logic/svwd_pkg.sv */
`default_nettype none
package svwd_pkg;
    typedef enum logic [3:0] {
        BS_IDLE, BS_DEV, BS_DEV_ACK, BS_ADDR, BS_ADDR_ACK, BS_DATA, BS_DATA_ACK,
        BS_READ, BS_READ_ACK, BS_IGNORE
    } svwd_bus_t;
endpackage
`default_nettype wire

/* logic/svwd_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser per bit for pin levels
module svwd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic clock, // system clock
    input wire logic rst, // sync reset
    input wire logic [WIDTH-1:0] din, // async inputs
    output logic [WIDTH-1:0] dout // synchronised levels
);
    logic [WIDTH-1:0] meta_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_reg <= INIT;
            dout <= INIT;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* logic/svwd_top.sv */
// Overview of operation
// - reset held while primary supply low, then for the chosen power-up delay.
// - second fail output held until second input exceeds trip plus hysteresis.
// - start then stop restarts the watchdog; timeout drives watchdog fail.
// - watchdog timeout chosen from two nonvolatile control register bits.
// - period 00=1.4s, 01=200ms, 10=25ms, 11=off (factory).
// - with program voltage, write A0h, 01h/09h, 00h and stop raises a trip level.
// - same qualified write with 03h/0Bh resets a trip level.
// - register selected by preamble 1011 and address 1FFh; single-byte writes only.
// - further data bytes to the register are not acknowledged.
// - stop after a settings data byte to the register starts the nonvolatile store.
// - register readable any time, one byte per read, no stop needed.
// - layout delay_hi, period hi/lo, protect, 0, reg latch, write latch, delay_lo.
// - settings write refused unless register write latch already set.
// - write latch clear at power-up; while clear, writes other than 02h/00h and trip writes are ignored and nacked.
// - 02h sets write latch, 00h clears it.
// - latch-only writes start no store; ready right after stop.
// - protect bit set ignores memory writes to 100h..1FFh.
// - delay 00=50ms, 01=200ms, 10=400ms, 11=800ms.
// - protect and watchdog settings survive power removal.
// - sequence 02h, 06h, settings; register latch clears after the store.
// - store finishes in bounded time; register writes ignored meanwhile.
`timescale 1ns/1ps
`default_nettype none
`include "svwd_consts.svh"
module svwd_top #(
    parameter bit RESET_ACTIVE_HIGH = 1'b0,
    parameter bit SELF_POWERED = 1'b1,
    parameter int unsigned CLK_KHZ = `SVWD_CLK_KHZ,
    parameter int unsigned NVW_CYC = `SVWD_NVW_MS * CLK_KHZ,
    parameter int unsigned WD0_CYC = `SVWD_WD0_MS * CLK_KHZ,
    parameter int unsigned WD1_CYC = `SVWD_WD1_MS * CLK_KHZ,
    parameter int unsigned WD2_CYC = `SVWD_WD2_MS * CLK_KHZ,
    parameter int unsigned PU0_CYC = `SVWD_PU0_MS * CLK_KHZ,
    parameter int unsigned PU1_CYC = `SVWD_PU1_MS * CLK_KHZ,
    parameter int unsigned PU2_CYC = `SVWD_PU2_MS * CLK_KHZ,
    parameter int unsigned PU3_CYC = `SVWD_PU3_MS * CLK_KHZ
) (
    input wire logic clock, // 50 MHz system clock
    input wire logic rst, // sync reset, active high (power-up)
    input wire logic scl_in, // bus clock pin
    input wire logic sda_in, // bus data pin level
    output logic sda_out, // always low when driving
    output logic sda_oe, // high while pulling sda low
    input wire logic primary_supply_ok, // comparator: primary above trip
    input wire logic second_supply_ok, // comparator: second above trip
    input wire logic second_supply_hyst_ok, // comparator: second above trip plus hysteresis
    input wire logic program_high_voltage, // qualifier on watchdog pin
    output logic sys_reset, // system reset, polarity by parameter
    output logic second_supply_fail, // high while second supply failed
    output logic wdog_fail_out, // high while watchdog expired
    output logic [1:0] trip_prog_cmd, // 01 raise, 10 reset; one-cycle pulse
    output logic trip_prog_sel, // 0 primary, 1 second level
    output logic mem_write_req, // one-cycle pulse: array byte write
    output logic [8:0] mem_write_addr, // array write address
    output logic [7:0] mem_write_data // array write data
);
    initial begin
        if (CLK_KHZ == 0 || NVW_CYC == 0 || WD2_CYC == 0 || PU0_CYC == 0) begin
            $error("svwd_top: counts must be nonzero");
        end
    end

    logic [5:0] syn;
    // bus pins idle high; supply inputs start as failed so no output releases before real levels arrive
    svwd_sync #(.WIDTH(6), .INIT(6'b110000)) u_sync (
        .clock(clock),
        .rst(rst),
        .din({scl_in, sda_in, primary_supply_ok, second_supply_ok, second_supply_hyst_ok, program_high_voltage}),
        .dout(syn)
    );
    wire scl_s = syn[5];
    wire sda_s = syn[4];
    wire v1_ok = syn[3];
    wire v2_ok = syn[2];
    wire v2_hyst_ok = syn[1];
    wire hv_s = syn[0];

    // bus condition detection
    logic scl_d_reg, sda_d_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end
    wire start_ev = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    wire stop_ev = scl_s && scl_d_reg && !sda_d_reg && sda_s;
    wire scl_rise = scl_s && !scl_d_reg;
    wire scl_fall = !scl_s && scl_d_reg;

    // control register state
    logic [4:0] nv_reg; // {dly_hi, wd_hi, wd_lo, prot, dly_lo}
    logic wel_reg, reg_write_latch_reg;
    wire [1:0] wd_sel = nv_reg[3:2];
    wire [1:0] dly_sel = {nv_reg[4], nv_reg[0]};
    wire prot = nv_reg[1];
    wire [7:0] creg_val = {nv_reg[4], nv_reg[3], nv_reg[2], nv_reg[1], 1'b0, reg_write_latch_reg, wel_reg, nv_reg[0]};

    // serial slave
    svwd_pkg::svwd_bus_t st_reg;
    logic [7:0] sh_reg;
    logic [3:0] bit_reg;
    logic [7:0] dev_reg, addr_reg, data_reg;
    logic is_read_reg, data_ok_reg, data_seen_reg, hv_at_start_reg, ack_reg;
    logic [7:0] tx_reg;
    logic nvw_busy_reg, pend_nv_reg, pend_prog_reg, pend_mem_reg;
    logic [23:0] nvw_cnt_reg;

    wire is_creg = dev_reg[7:4] == `SVWD_CREG_PRE;
    wire [8:0] waddr = {dev_reg[1], addr_reg};
    wire creg_hit = is_creg && waddr == `SVWD_CREG_ADDR;
    wire prog_hit = hv_at_start_reg && dev_reg == `SVWD_PROG_DEV
        && (addr_reg == `SVWD_PROG_V1_SET || addr_reg == `SVWD_PROG_V2_SET
        || addr_reg == `SVWD_PROG_V1_CLR || addr_reg == `SVWD_PROG_V2_CLR);
    wire wel_cmd = sh_reg == `SVWD_DATA_WEL_SET || sh_reg == `SVWD_DATA_WEL_CLR;
    wire reg_write_latch_cmd = sh_reg[3] == 1'b0 && sh_reg[2] && sh_reg[1];
    wire mem_prot = prot && waddr >= `SVWD_PROT_BASE;
    // decide ack for incoming data byte
    // the latch command itself must get through while the latch is still clear
    wire data_ack = !data_seen_reg && (prog_hit || (!nvw_busy_reg
        && (creg_hit ? (wel_cmd || (wel_reg && (reg_write_latch_cmd || reg_write_latch_reg)))
        : (wel_reg && !is_creg && !mem_prot))));
    wire dev_match = dev_reg[7:4] == 4'ha || dev_reg[7:4] == `SVWD_CREG_PRE;

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= svwd_pkg::BS_IDLE;
            sh_reg <= 8'h00;
            bit_reg <= 4'h0;
            dev_reg <= 8'h00;
            addr_reg <= 8'h00;
            data_reg <= 8'h00;
            is_read_reg <= 1'b0;
            data_ok_reg <= 1'b0;
            data_seen_reg <= 1'b0;
            hv_at_start_reg <= 1'b0;
            ack_reg <= 1'b0;
            tx_reg <= 8'hff;
        end else if (start_ev) begin
            st_reg <= svwd_pkg::BS_DEV;
            bit_reg <= 4'h0;
            data_ok_reg <= 1'b0;
            data_seen_reg <= 1'b0;
            hv_at_start_reg <= hv_s;
            ack_reg <= 1'b0;
        end else if (stop_ev) begin
            st_reg <= svwd_pkg::BS_IDLE;
            ack_reg <= 1'b0;
        end else begin
            case (st_reg)
                svwd_pkg::BS_DEV, svwd_pkg::BS_ADDR, svwd_pkg::BS_DATA: begin
                    if (scl_rise) begin
                        sh_reg <= {sh_reg[6:0], sda_s};
                        bit_reg <= bit_reg + 4'h1;
                    end
                    if (scl_fall && bit_reg == 4'h8) begin
                        bit_reg <= 4'h0;
                        if (st_reg == svwd_pkg::BS_DEV) begin
                            dev_reg <= sh_reg;
                            is_read_reg <= sh_reg[0];
                            ack_reg <= sh_reg[7:4] == 4'ha || sh_reg[7:4] == `SVWD_CREG_PRE;
                            st_reg <= svwd_pkg::BS_DEV_ACK;
                        end else if (st_reg == svwd_pkg::BS_ADDR) begin
                            addr_reg <= sh_reg;
                            ack_reg <= 1'b1;
                            st_reg <= svwd_pkg::BS_ADDR_ACK;
                        end else begin
                            data_reg <= sh_reg;
                            ack_reg <= data_ack;
                            data_ok_reg <= data_ack;
                            data_seen_reg <= 1'b1;
                            st_reg <= svwd_pkg::BS_DATA_ACK;
                        end
                    end
                end
                svwd_pkg::BS_DEV_ACK, svwd_pkg::BS_ADDR_ACK, svwd_pkg::BS_DATA_ACK: begin
                    if (scl_fall) begin
                        ack_reg <= 1'b0;
                        if (st_reg == svwd_pkg::BS_DEV_ACK && !dev_match) begin
                            st_reg <= svwd_pkg::BS_IGNORE;
                        end else if (st_reg == svwd_pkg::BS_DEV_ACK && is_read_reg) begin
                            // one byte: register value, else bus released
                            tx_reg <= creg_hit ? creg_val : 8'hff;
                            st_reg <= svwd_pkg::BS_READ;
                        end else if (st_reg == svwd_pkg::BS_DEV_ACK) begin
                            st_reg <= svwd_pkg::BS_ADDR;
                        end else begin
                            st_reg <= svwd_pkg::BS_DATA;
                        end
                    end
                end
                svwd_pkg::BS_READ: begin
                    if (scl_fall) begin
                        tx_reg <= {tx_reg[6:0], 1'b1};
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == 4'h7) begin
                            st_reg <= svwd_pkg::BS_READ_ACK;
                        end
                    end
                end
                svwd_pkg::BS_READ_ACK: begin
                    if (scl_fall) begin
                        st_reg <= svwd_pkg::BS_IGNORE;
                    end
                end
                svwd_pkg::BS_IGNORE, svwd_pkg::BS_IDLE: begin
                end
                default: st_reg <= svwd_pkg::BS_IDLE;
            endcase
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe = ack_reg || (st_reg == svwd_pkg::BS_READ && !tx_reg[7]);

    // actions at stop
    wire commit = stop_ev && data_ok_reg && st_reg != svwd_pkg::BS_IDLE;
    wire do_prog = commit && prog_hit && data_reg == 8'h00;
    wire do_creg = commit && !prog_hit && creg_hit;
    wire do_mem = commit && !prog_hit && !is_creg;
    wire creg_wel_only = data_reg == `SVWD_DATA_WEL_SET || data_reg == `SVWD_DATA_WEL_CLR;
    wire creg_reg_write_latch_set = data_reg[2];

    always_ff @(posedge clock) begin
        if (rst) begin
            wel_reg <= 1'b0;
            reg_write_latch_reg <= 1'b0;
            nvw_busy_reg <= 1'b0;
            nvw_cnt_reg <= 24'h000000;
            trip_prog_cmd <= 2'b00;
            trip_prog_sel <= 1'b0;
            mem_write_req <= 1'b0;
            mem_write_addr <= 9'h000;
            mem_write_data <= 8'h00;
        end else begin
            trip_prog_cmd <= 2'b00;
            mem_write_req <= 1'b0;
            if (do_prog) begin
                trip_prog_cmd <= addr_reg[1] ? 2'b10 : 2'b01;
                trip_prog_sel <= addr_reg[3];
            end
            if (do_creg && creg_wel_only) begin
                wel_reg <= data_reg[1];
            end else if (do_creg && creg_reg_write_latch_set) begin
                reg_write_latch_reg <= 1'b1;
                wel_reg <= data_reg[1];
            end else if (do_creg) begin
                nvw_busy_reg <= 1'b1;
                nvw_cnt_reg <= 24'(NVW_CYC - 1);
            end
            if (do_mem) begin
                mem_write_req <= 1'b1;
                mem_write_addr <= waddr;
                mem_write_data <= data_reg;
            end
            if (nvw_busy_reg) begin
                if (nvw_cnt_reg == 24'h000000) begin
                    nvw_busy_reg <= 1'b0;
                    reg_write_latch_reg <= 1'b0;
                end else begin
                    nvw_cnt_reg <= nvw_cnt_reg - 24'h000001;
                end
            end
        end
    end

    // nonvolatile settings: in silicon the cell holds these; rst models a factory-fresh part only
    always_ff @(posedge clock) begin
        if (rst) begin
            nv_reg <= `SVWD_NV_RESET;
        end else if (do_creg && !creg_wel_only && !creg_reg_write_latch_set) begin
            nv_reg <= {data_reg[7], data_reg[6], data_reg[5], data_reg[4], data_reg[0]};
        end
    end

    // watchdog
    logic [31:0] wd_cnt_reg;
    logic armed_reg;
    wire [31:0] wd_limit = wd_sel == 2'b00 ? 32'(WD0_CYC) : wd_sel == 2'b01 ? 32'(WD1_CYC) : 32'(WD2_CYC);
    always_ff @(posedge clock) begin
        if (rst) begin
            wd_cnt_reg <= 32'h00000000;
            armed_reg <= 1'b0;
            wdog_fail_out <= 1'b0;
        end else begin
            if (start_ev) begin
                armed_reg <= 1'b1;
            end
            if (stop_ev && armed_reg) begin
                wd_cnt_reg <= 32'h00000000;
                armed_reg <= 1'b0;
                wdog_fail_out <= 1'b0;
            end else if (wd_sel == 2'b11 || !v1_ok) begin
                wd_cnt_reg <= 32'h00000000;
                wdog_fail_out <= 1'b0;
            end else if (wd_cnt_reg >= wd_limit - 32'h00000001) begin
                wdog_fail_out <= 1'b1;
            end else begin
                wd_cnt_reg <= wd_cnt_reg + 32'h00000001;
            end
        end
    end

    // power-up reset delay
    logic [31:0] pu_cnt_reg;
    logic rst_act_reg;
    wire [31:0] pu_limit = dly_sel == 2'b00 ? 32'(PU0_CYC) : dly_sel == 2'b01 ? 32'(PU1_CYC)
        : dly_sel == 2'b10 ? 32'(PU2_CYC) : 32'(PU3_CYC);
    always_ff @(posedge clock) begin
        if (rst) begin
            pu_cnt_reg <= 32'h00000000;
            rst_act_reg <= 1'b1;
        end else if (!v1_ok) begin
            pu_cnt_reg <= 32'h00000000;
            rst_act_reg <= 1'b1;
        end else if (pu_cnt_reg >= pu_limit - 32'h00000001) begin
            rst_act_reg <= 1'b0;
        end else begin
            pu_cnt_reg <= pu_cnt_reg + 32'h00000001;
        end
    end
    assign sys_reset = RESET_ACTIVE_HIGH ? rst_act_reg : !rst_act_reg;

    // second supply fail with hysteresis on self-powered variant
    always_ff @(posedge clock) begin
        if (rst) begin
            second_supply_fail <= 1'b1;
        end else if (!v2_ok) begin
            second_supply_fail <= 1'b1;
        end else if (SELF_POWERED ? v2_hyst_ok : v2_ok) begin
            second_supply_fail <= 1'b0;
        end
    end

    a_reset_low_supply: assert property (@(posedge clock) disable iff (rst)
        !v1_ok |=> rst_act_reg) else $error("reset not held on low supply");
    a_wdog_restart: assert property (@(posedge clock) disable iff (rst)
        (stop_ev && armed_reg) |=> !wdog_fail_out) else $error("watchdog not restarted");
    a_wdog_off: assert property (@(posedge clock) disable iff (rst)
        (wd_sel == 2'b11) |=> !wdog_fail_out) else $error("disabled watchdog fired");
    a_store_clears_reg_write_latch: assert property (@(posedge clock) disable iff (rst)
        $fell(nvw_busy_reg) |-> !reg_write_latch_reg) else $error("register latch not cleared");
    a_no_ack_wel_clear: assert property (@(posedge clock) disable iff (rst)
        (st_reg == svwd_pkg::BS_DATA && scl_fall && bit_reg == 4'h8 && !wel_reg && !prog_hit
        && !(creg_hit && wel_cmd))
        |=> !ack_reg) else $error("ack without write latch");
    a_second_byte_nack: assert property (@(posedge clock) disable iff (rst)
        (st_reg == svwd_pkg::BS_DATA && scl_fall && bit_reg == 4'h8 && data_seen_reg)
        |=> !ack_reg) else $error("second data byte acked");
    a_wel_only_no_store: assert property (@(posedge clock) disable iff (rst)
        (do_creg && creg_wel_only && !nvw_busy_reg) |=> !nvw_busy_reg) else $error("latch write began store");
    a_nv_guarded: assert property (@(posedge clock) disable iff (rst)
        $changed(nv_reg) |-> $past(reg_write_latch_reg) && $past(wel_reg)) else $error("settings changed unguarded");
    a_prot_nack: assert property (@(posedge clock) disable iff (rst)
        (st_reg == svwd_pkg::BS_DATA && scl_fall && bit_reg == 4'h8 && mem_prot && !is_creg && !prog_hit)
        |=> !ack_reg) else $error("protected write acked");
endmodule
`default_nettype wire

/* tb/svwd_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
// bus master model; every edge comes off the system clock, two cycles a quarter bit (160 ns bit)
module svwd_bus_master (
    input wire logic clock, // system clock
    output logic scl, // bus clock, high when idle
    output logic sda_low, // high while the master pulls sda low
    input wire logic sda // resolved data line level
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q();
        repeat (2) @(posedge clock);
    endtask
    // also serves as repeated start: sda is released before scl rises
    task automatic start();
        sda_low <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_low <= 1'b0;
        q();
        q();
    endtask
    // sda changes only while scl is low; sampled in mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda_low <= ~b;
        q();
        scl <= 1'b1;
        q();
        r = sda;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic write_byte(input logic [7:0] v, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], r);
        end
        bit_io(1'b1, nack);
    endtask
    task automatic read_byte(input logic ack_it, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        bit_io(~ack_it, r);
    endtask
endmodule
`default_nettype wire

/* tb/svwd_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module svwd_top_test;
    localparam int PU0 = 100;
    localparam int PU1 = 200;
    localparam int WD2 = 600;
    localparam int NVW = 2000;
    logic clock;
    logic rst = 1'b1;
    logic prim_ok = 1'b0;
    logic sec_ok = 1'b0;
    logic sec_hyst = 1'b0;
    logic prog_hv = 1'b0;
    logic scl, m_low, sda_oe, sys_reset, sec_fail, wdog, mw_req, tp_sel;
    logic [1:0] tp_cmd;
    logic [8:0] mw_addr;
    logic [7:0] mw_data;
    wire sda;
    int checks = 0;
    int fail_count = 0;
    int mw_count = 0;
    int tp_count = 0;
    logic [1:0] last_cmd;
    logic last_sel;
    logic [8:0] last_addr;
    logic [7:0] last_data;
    logic [7:0] d;
    logic nk, nk2;
    int n;
    logic [7:0] trip_addr [4] = '{8'h03, 8'h01, 8'h0b, 8'h09};
    // pull-up: released line reads high
    assign sda = (m_low | sda_oe) ? 1'b0 : 1'b1;
    svwd_bus_master m (.clock(clock), .scl(scl), .sda_low(m_low), .sda(sda));
    svwd_top #(.RESET_ACTIVE_HIGH(1'b0), .NVW_CYC(NVW), .WD0_CYC(3000), .WD1_CYC(1500), .WD2_CYC(WD2),
        .PU0_CYC(PU0), .PU1_CYC(PU1), .PU2_CYC(400), .PU3_CYC(800)) DUT (
        .clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .primary_supply_ok(prim_ok), .second_supply_ok(sec_ok), .second_supply_hyst_ok(sec_hyst),
        .program_high_voltage(prog_hv), .sys_reset(sys_reset), .second_supply_fail(sec_fail),
        .wdog_fail_out(wdog), .trip_prog_cmd(tp_cmd), .trip_prog_sel(tp_sel), .mem_write_req(mw_req),
        .mem_write_addr(mw_addr), .mem_write_data(mw_data));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        if (mw_req === 1'b1) begin
            mw_count <= mw_count + 1;
            last_addr <= mw_addr;
            last_data <= mw_data;
        end
        if (tp_cmd !== 2'b00) begin
            tp_count <= tp_count + 1;
            last_cmd <= tp_cmd;
            last_sel <= tp_sel;
        end
    end
    task automatic finish_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    // sel 0 reset output, 1 watchdog output, 2 second supply fail
    task automatic wait_sig(input int sel, input logic lvl, input int bound, output int cnt);
        logic v;
        cnt = 0;
        while (cnt < bound) begin
            v = (sel == 0) ? sys_reset : (sel == 1) ? wdog : sec_fail;
            if (v === lvl) break;
            @(posedge clock);
            cnt++;
        end
        if (cnt >= bound) begin
            fail_count++;
            $display("FAIL wait %0d expected %b seen timeout", sel, lvl);
            finish_test();
        end
    endtask
    task automatic wr3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, output logic nack);
        logic x;
        m.start();
        m.write_byte(a, x);
        m.write_byte(b, x);
        m.write_byte(c, nack);
        m.stop();
    endtask
    // register read ends without a stop; the next transfer opens with a start
    task automatic reg_read(output logic [7:0] v);
        logic x;
        m.start();
        m.write_byte(8'hb2, x);
        m.write_byte(8'hff, x);
        m.start();
        m.write_byte(8'hb3, x);
        m.read_byte(1'b0, v);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (4) @(posedge clock);
        check("reset low supply", 8'h00, 8'(sys_reset));
        check("second fail", 8'h01, 8'(sec_fail));
        sec_ok <= 1'b1;
        repeat (20) @(posedge clock);
        check("second fail no margin", 8'h01, 8'(sec_fail));
        sec_hyst <= 1'b1;
        wait_sig(2, 1'b0, 20, n);
        prim_ok <= 1'b1;
        wait_sig(0, 1'b1, PU1 + 20, n);
        check("delay 01", 8'h01, 8'(n >= PU1 && n <= PU1 + 8));
        reg_read(d);
        check("factory reg", 8'h61, d);
        wr3(8'hb2, 8'hff, 8'h06, nk);
        check("write latch clear", 8'h01, 8'(nk));
        wr3(8'hb2, 8'hff, 8'h02, nk);
        check("set write latch", 8'h00, 8'(nk));
        reg_read(d);
        check("reg after 02", 8'h63, d);
        wr3(8'hb2, 8'hff, 8'h00, nk);
        reg_read(d);
        check("reg after 00", 8'h61, d);
        wr3(8'hb2, 8'hff, 8'h02, nk);
        m.start();
        m.write_byte(8'hb2, nk);
        m.write_byte(8'hff, nk);
        m.write_byte(8'h02, nk);
        m.write_byte(8'h02, nk2);
        m.stop();
        check("second data byte", 8'h01, 8'(nk2));
        wr3(8'hb2, 8'hff, 8'h52, nk);
        check("settings no reg latch", 8'h01, 8'(nk));
        wr3(8'hb2, 8'hff, 8'h06, nk);
        reg_read(d);
        check("reg latch set", 8'h67, d);
        wr3(8'hb2, 8'hff, 8'h52, nk);
        check("settings write", 8'h00, 8'(nk));
        wr3(8'hb2, 8'hff, 8'h02, nk);
        check("write during store", 8'h01, 8'(nk));
        repeat (NVW + 20) @(posedge clock);
        reg_read(d);
        check("stored settings", 8'h50, d & 8'hfd);
        wr3(8'hb2, 8'hff, 8'h02, nk);
        wr3(8'ha2, 8'h10, 8'h55, nk);
        check("protected nack", 8'h01, 8'(nk));
        check("protected no write", 8'h00, 8'(mw_count));
        wr3(8'ha0, 8'h10, 8'h5a, nk);
        repeat (2) @(posedge clock);
        check("lower half write", 8'h01, 8'(mw_count));
        check("lower half addr", 8'h10, last_addr[7:0]);
        check("lower half data", 8'h5a, last_data);
        repeat (NVW + 20) @(posedge clock);
        for (int i = 0; i < 3; i++) begin
            m.start();
            m.stop();
            repeat (WD2 / 2) @(posedge clock);
            check("watchdog restarted", 8'h00, 8'(wdog));
        end
        m.start();
        m.stop();
        wait_sig(1, 1'b1, WD2 + 50, n);
        check("watchdog 25ms", 8'h01, 8'(n >= WD2 - 10 && n <= WD2 + 4));
        prim_ok <= 1'b0;
        wait_sig(0, 1'b0, 10, n);
        repeat (4) @(posedge clock);
        check("watchdog held low supply", 8'h00, 8'(wdog));
        prim_ok <= 1'b1;
        wait_sig(0, 1'b1, PU0 + 20, n);
        check("delay 00", 8'h01, 8'(n >= PU0 && n <= PU0 + 8));
        // each level is reset before it is raised
        for (int i = 0; i < 4; i++) begin
            prog_hv <= 1'b1;
            repeat (4) @(posedge clock);
            wr3(8'ha0, trip_addr[i], 8'h00, nk);
            repeat (6) @(posedge clock);
            check("trip count", 8'(i + 1), 8'(tp_count));
            check("trip cmd", (i % 2 == 0) ? 8'h02 : 8'h01, 8'(last_cmd));
            check("trip sel", 8'(i / 2), 8'(last_sel));
            prog_hv <= 1'b0;
            repeat (10) @(posedge clock);
        end
        finish_test();
    end
endmodule
`default_nettype wire
